/* File: logic/dscu_consts.svh */
// constants of the drive speed command unit: selector codes, defaults, timing
// assumes a 50 MHz control clock; included by bare name
//
// Summary of operation
// - source 3 is 4-20 mA, 4 is 0-20 mA
// - run source 0 takes panel keys
// - run source 1 takes terminal fwd/rev switches
// - current span maps linearly to 0-100 % maximum
// - gain and bias apply to current reference
// - pulse reference is rate over full scale times maximum
// - full-scale pulse rate 100..3300, default 2500
// - function 37 selects direction, function 1 runs
// - functions 2 and 37 together rejected, error raised
// - conflict written by link inhibits operation
// - input 3 nonzero gives traditional two-wire when no input has function 37
// - input 3 at zero gives three-wire when no input has function 37
// - accel stall level default 170, 200 disables
// - accel stall holds frequency, 5 % hysteresis
// - accel level scaled down above voltage frequency
// - run stall level default 160, 200 disables
// - over run level 100 ms at agreement decelerates
// - stall ramps use selected time pair
// - base-speed option lowers run level, default off
`ifndef DSCU_CONSTS_SVH
`define DSCU_CONSTS_SVH
`define DSCU_RUN_SRC_PANEL 2'h0
`define DSCU_RUN_SRC_TERM 2'h1
`define DSCU_REF_SRC_I4_20 4'h3
`define DSCU_REF_SRC_I0_20 4'h4
`define DSCU_REF_SRC_PULSE 4'h5
`define DSCU_FN_THREE_WIRE 6'h00
`define DSCU_FN_FWD_RUN 6'h01
`define DSCU_FN_REV_RUN 6'h02
`define DSCU_FN_FR_RUN2 6'h25
`define DSCU_PULSE_FS_MIN 12'h064
`define DSCU_PULSE_FS_MAX 12'hCE4
`define DSCU_PULSE_FS_RST 12'h9C4
`define DSCU_STALL_ACC_RST 8'hAA
`define DSCU_STALL_RUN_RST 8'hA0
`define DSCU_STALL_OFF 8'hC8
`define DSCU_STALL_HYST 9'h005
`define DSCU_ADC_4MA 12'h333
`define DSCU_GAIN_RST 8'h64
`define DSCU_MAXF_RST 16'h0258
`define DSCU_CLK_HZ 50000000
`define DSCU_RUN_STALL_MS 100
`define DSCU_GATE_MS 100
`define DSCU_RUN_STALL_CYC (`DSCU_CLK_HZ / 1000 * `DSCU_RUN_STALL_MS)
`define DSCU_GATE_CYC (`DSCU_CLK_HZ / 1000 * `DSCU_GATE_MS)
`endif

/* File: logic/dscu_pkg.sv */
// types shared by the drive speed command unit
// assumes nothing of its surroundings
`default_nettype none
package dscu_pkg;
  typedef struct packed {
    logic [1:0] run_source_select;
    logic [3:0] reference_source_select;
    logic [11:0] pulse_full_scale_rate;
    logic [5:0] input1_function;
    logic [5:0] input2_function;
    logic [5:0] input3_function;
    logic [7:0] reference_gain;
    logic [7:0] reference_bias;
    logic [15:0] max_output_frequency;
    logic [15:0] max_voltage_frequency;
    logic [7:0] accel_stall_level;
    logic [7:0] run_stall_level;
    logic base_speed_stall_reduce;
    logic [15:0] accel_time_set1;
    logic [15:0] decel_time_set1;
    logic [15:0] accel_time_set2;
    logic [15:0] decel_time_set2;
  } dscu_cfg_t;
  typedef struct packed {
    logic run_cmd;
    logic reverse_cmd;
    logic accel_hold;
    logic stall_decel;
    logic setting_error;
    logic comm_setting_error;
    logic run_inhibit;
    logic [15:0] freq_ref;
    logic [15:0] output_freq;
  } dscu_status_t;
  typedef enum logic [1:0] {
    DSCU_RS_STEADY = 2'b00,
    DSCU_RS_ACCEL = 2'b01,
    DSCU_RS_DECEL = 2'b10,
    DSCU_RS_HOLD = 2'b11
  } dscu_ramp_t;
endpackage
`default_nettype wire

/* File: logic/dscu_pulse_meter.sv */
// pulse-train reference: counts rising edges per gate, then scales by division
// assumes pulse_in synchronous to clk, full_scale within its legal range
`timescale 1ns/100ps
`default_nettype none
`include "dscu_consts.svh"
module dscu_pulse_meter #(
  parameter int GATE_CYC = `DSCU_GATE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pulse_in,
  input wire logic [11:0] full_scale,
  input wire logic [15:0] max_freq,
  output logic [15:0] freq
);
  // the serial divide needs 29 cycles, so a shorter gate would restart it mid-way
  if (GATE_CYC < 30)
  begin : g_chk
    $error("gate shorter than the divide");
  end
  logic [$clog2(GATE_CYC)-1:0] gate_cnt;
  logic [11:0] edges;
  logic prev;
  logic [27:0] num;
  logic [12:0] rem;
  logic [27:0] quo;
  logic [4:0] steps;
  logic [12:0] rem_s;
  logic gate_end;
  assign gate_end = gate_cnt == ($clog2(GATE_CYC))'(GATE_CYC - 1);
  assign rem_s = {rem[11:0], num[27]};
  // edges per 100 ms gate equal the rate in 10 Hz units
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_cnt <= '0;
      edges <= 12'h000;
      prev <= 1'b0;
    end
    else if (ce)
    begin
      prev <= pulse_in;
      gate_cnt <= gate_end ? '0 : gate_cnt + 1'b1;
      // an edge on the last gate cycle opens the next count, so none is lost
      if (gate_end)
        edges <= {11'h000, pulse_in && !prev};
      else if (pulse_in && !prev && edges != 12'hFFF)
        edges <= edges + 12'h001;
    end
  end
  // serial restoring divide, 28 steps, well inside one gate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      num <= '0;
      rem <= '0;
      quo <= '0;
      steps <= 5'h00;
      freq <= 16'h0000;
    end
    else if (ce)
    begin
      if (gate_end)
      begin
        // rates above full scale saturate at 100 %
        num <= ((edges > full_scale) ? full_scale : edges) * max_freq;
        rem <= '0;
        quo <= '0;
        steps <= 5'h1C;
      end
      else if (steps != 5'h00)
      begin
        num <= {num[26:0], 1'b0};
        rem <= (rem_s >= {1'b0, full_scale}) ? rem_s - {1'b0, full_scale} : rem_s;
        quo <= {quo[26:0], rem_s >= {1'b0, full_scale}};
        steps <= steps - 5'h01;
        if (steps == 5'h01)
          freq <= {quo[14:0], rem_s >= {1'b0, full_scale}};
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/dscu_stall_timer.sv */
// qualification timer: done after COUNT cycles of arm held high
// assumes a single clock; arm low restarts the count
`timescale 1ns/100ps
`default_nettype none
module dscu_stall_timer #(
  parameter int COUNT = 5000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic arm,
  output logic done
);
  if (COUNT < 2)
  begin : g_chk
    $error("count too short");
  end
  logic [$clog2(COUNT+1)-1:0] cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      if (!arm)
      begin
        cnt <= '0;
        done <= 1'b0;
      end
      else if (!done)
      begin
        cnt <= cnt + 1'b1;
        done <= cnt == ($clog2(COUNT+1))'(COUNT - 1);
      end
    end
  end
  a_timer_full: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(done) |-> $past(cnt) == ($clog2(COUNT+1))'(COUNT - 1))
    else $error("stall timer ended early");
endmodule
`default_nettype wire

/* File: logic/dscu_top.sv */
// drive speed command unit: run source, sequence decode, reference, stall ramp
// assumes all inputs synchronous to mclk and config applied by cfg_load
`timescale 1ns/100ps
`default_nettype none
`include "dscu_consts.svh"
module dscu_top #(
  parameter int RUN_STALL_CYC = `DSCU_RUN_STALL_CYC,
  parameter int GATE_CYC = `DSCU_GATE_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire dscu_pkg::dscu_cfg_t cfg_in,
  input wire logic cfg_load,
  input wire logic cfg_from_comm,
  input wire logic key_run,
  input wire logic key_stop,
  input wire logic panel_reverse,
  input wire logic [2:0] terminal_in,
  input wire logic [11:0] current_ref_adc,
  input wire logic pulse_in,
  input wire logic [15:0] digital_reference,
  input wire logic [8:0] output_current,
  input wire logic accel_set_select,
  output dscu_pkg::dscu_status_t status
);
  import dscu_pkg::*;
  if (RUN_STALL_CYC < 2)
  begin : g_chk
    $error("run stall count too short");
  end

  function automatic logic has_fn(input dscu_cfg_t c, input logic [5:0] fn);
    has_fn = c.input1_function == fn || c.input2_function == fn || c.input3_function == fn;
  endfunction

  // current times scale against level times voltage frequency, so no divider
  function automatic logic stall_over(input logic [8:0] cur, input logic [7:0] lvl,
                                      input logic [15:0] mulf, input logic [15:0] fv);
    logic [25:0] a;
    logic [25:0] b;
    a = {17'h0, cur} * {10'h0, mulf};
    b = {18'h0, lvl} * {10'h0, fv};
    stall_over = (lvl != `DSCU_STALL_OFF) && (a > b);
  endfunction

  // percent of a value; 1311/2^17 stands in for 1/100 within 0.03 %
  function automatic logic [16:0] pct(input logic [15:0] v, input logic [7:0] p);
    logic [39:0] m;
    m = {24'h0, v} * {32'h0, p} * 40'd1311;
    pct = (m[39:17] > 23'h00FFFF) ? 17'h0FFFF : m[33:17];
  endfunction

  logic rst_s1;
  logic rst_n;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // configuration is taken only when consistent
  dscu_cfg_t act;
  logic setting_error;
  logic comm_err;
  logic conflict;
  assign conflict = has_fn(cfg_in, `DSCU_FN_REV_RUN) && has_fn(cfg_in, `DSCU_FN_FR_RUN2);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act <= '0;
      act.reference_source_select <= 4'h1;
      act.pulse_full_scale_rate <= `DSCU_PULSE_FS_RST;
      act.input1_function <= `DSCU_FN_FWD_RUN;
      act.input2_function <= `DSCU_FN_REV_RUN;
      act.input3_function <= 6'h05;
      act.reference_gain <= `DSCU_GAIN_RST;
      act.max_output_frequency <= `DSCU_MAXF_RST;
      act.max_voltage_frequency <= `DSCU_MAXF_RST;
      act.accel_stall_level <= `DSCU_STALL_ACC_RST;
      act.run_stall_level <= `DSCU_STALL_RUN_RST;
      act.accel_time_set1 <= 16'h00FF;
      act.decel_time_set1 <= 16'h00FF;
      act.accel_time_set2 <= 16'h00FF;
      act.decel_time_set2 <= 16'h00FF;
      setting_error <= 1'b0;
      comm_err <= 1'b0;
    end
    else if (ce && cfg_load)
    begin
      if (conflict)
      begin
        setting_error <= 1'b1;
        if (cfg_from_comm)
          comm_err <= 1'b1;
      end
      else
      begin
        act <= cfg_in;
        // an out-of-range full scale is clamped rather than refused
        if (cfg_in.pulse_full_scale_rate < `DSCU_PULSE_FS_MIN)
          act.pulse_full_scale_rate <= `DSCU_PULSE_FS_MIN;
        else if (cfg_in.pulse_full_scale_rate > `DSCU_PULSE_FS_MAX)
          act.pulse_full_scale_rate <= `DSCU_PULSE_FS_MAX;
        setting_error <= 1'b0;
        comm_err <= 1'b0;
      end
    end
  end

  // per-terminal function decode
  logic [2:0] fwd_on;
  logic [2:0] rev_on;
  logic [2:0] fr2_on;
  logic [5:0] fn [3];
  assign fn[0] = act.input1_function;
  assign fn[1] = act.input2_function;
  assign fn[2] = act.input3_function;
  for (genvar i = 0; i < 3; i++)
  begin : g_term
    assign fwd_on[i] = terminal_in[i] && fn[i] == `DSCU_FN_FWD_RUN;
    assign rev_on[i] = terminal_in[i] && fn[i] == `DSCU_FN_REV_RUN;
    assign fr2_on[i] = terminal_in[i] && fn[i] == `DSCU_FN_FR_RUN2;
  end
  logic seq2;
  logic three_wire;
  assign seq2 = has_fn(act, `DSCU_FN_FR_RUN2);
  assign three_wire = act.input3_function == `DSCU_FN_THREE_WIRE;

  logic panel_run;
  logic run3;
  logic run_cmd;
  logic reverse_cmd;
  logic next_panel;
  logic next_run3;
  logic next_run;
  logic next_rev;
  logic t_run;
  logic t_rev;
  always_comb
  begin
    next_panel = panel_run;
    if (key_stop)
      next_panel = 1'b0;
    else if (key_run)
      next_panel = 1'b1;
    // three-wire: input 2 is a break contact, input 1 a momentary start
    next_run3 = run3;
    if (!terminal_in[1])
      next_run3 = 1'b0;
    else if (terminal_in[0])
      next_run3 = 1'b1;
    if (seq2)
    begin
      t_run = |fwd_on;
      t_rev = ~|fr2_on;
    end
    else if (three_wire)
    begin
      t_run = next_run3;
      t_rev = terminal_in[2];
    end
    else
    begin
      // both switches closed means stop
      t_run = (|fwd_on) ^ (|rev_on);
      t_rev = (|rev_on) & ~(|fwd_on);
    end
    case (act.run_source_select)
      `DSCU_RUN_SRC_PANEL:
      begin
        next_run = next_panel;
        next_rev = panel_reverse;
      end
      `DSCU_RUN_SRC_TERM:
      begin
        next_run = t_run;
        next_rev = t_rev;
      end
      default:
      begin
        next_run = 1'b0;
        next_rev = reverse_cmd;
      end
    endcase
    if (comm_err)
      next_run = 1'b0;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      panel_run <= 1'b0;
      run3 <= 1'b0;
      run_cmd <= 1'b0;
      reverse_cmd <= 1'b0;
    end
    else if (ce)
    begin
      panel_run <= next_panel;
      run3 <= next_run3;
      run_cmd <= next_run;
      reverse_cmd <= next_rev;
    end
  end

  // frequency reference
  logic [15:0] pulse_freq;
  dscu_pulse_meter #(.GATE_CYC(GATE_CYC)) u_pulse (
    .clk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .pulse_in(pulse_in),
    .full_scale(act.pulse_full_scale_rate),
    .max_freq(act.max_output_frequency),
    .freq(pulse_freq)
  );
  logic [11:0] span_x;
  logic [31:0] span_mul;
  logic [15:0] raw;
  logic [17:0] biased;
  logic [15:0] scaled;
  logic [15:0] freq_ref;
  always_comb
  begin
    span_x = (current_ref_adc < `DSCU_ADC_4MA) ? 12'h000 : current_ref_adc - `DSCU_ADC_4MA;
    if (act.reference_source_select == `DSCU_REF_SRC_I4_20)
    begin
      // 16 mA span is 0.8 of full code, so times 5 over 2^14
      span_mul = {20'h0, span_x} * {16'h0, act.max_output_frequency} * 32'd5;
      raw = span_mul[29:14];
    end
    else
    begin
      span_mul = {20'h0, current_ref_adc} * {16'h0, act.max_output_frequency};
      raw = span_mul[27:12];
    end
    biased = {1'b0, pct(raw, act.reference_gain)} + {1'b0, pct(act.max_output_frequency, act.reference_bias)};
    scaled = (biased > {2'h0, act.max_output_frequency}) ? act.max_output_frequency : biased[15:0];
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      freq_ref <= 16'h0000;
    else if (ce)
    begin
      case (act.reference_source_select)
        `DSCU_REF_SRC_I4_20, `DSCU_REF_SRC_I0_20: freq_ref <= scaled;
        `DSCU_REF_SRC_PULSE: freq_ref <= pulse_freq;
        default: freq_ref <= digital_reference;
      endcase
    end
  end

  // stall prevention
  logic [15:0] out_f;
  logic accel_hold;
  logic stall_decel;
  logic [15:0] target;
  logic [15:0] mul_acc;
  logic [15:0] mul_run;
  logic over_run;
  logic agree;
  logic timer_done;
  assign target = run_cmd ? freq_ref : 16'h0000;
  assign mul_acc = (out_f > act.max_voltage_frequency) ? out_f : act.max_voltage_frequency;
  assign mul_run = (act.base_speed_stall_reduce && out_f > act.max_voltage_frequency) ?
                   out_f : act.max_voltage_frequency;
  assign over_run = stall_over(output_current, act.run_stall_level, mul_run, act.max_voltage_frequency);
  assign agree = run_cmd && out_f == freq_ref && freq_ref != 16'h0000;
  dscu_stall_timer #(.COUNT(RUN_STALL_CYC)) u_timer (
    .clk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .arm(agree && over_run),
    .done(timer_done)
  );
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accel_hold <= 1'b0;
      stall_decel <= 1'b0;
    end
    else if (ce)
    begin
      if (!(out_f < target))
        accel_hold <= 1'b0;
      else if (stall_over(output_current, act.accel_stall_level, mul_acc, act.max_voltage_frequency))
        accel_hold <= 1'b1;
      else if (!stall_over(output_current + `DSCU_STALL_HYST, act.accel_stall_level, mul_acc,
                           act.max_voltage_frequency))
        accel_hold <= 1'b0;
      if (!over_run || !run_cmd)
        stall_decel <= 1'b0;
      else if (timer_done)
        stall_decel <= 1'b1;
    end
  end

  // output ramp, one 0.1 Hz step per time-setting cycles
  dscu_ramp_t ramp;
  dscu_ramp_t next_ramp;
  logic [15:0] tick_cnt;
  logic [15:0] period;
  logic tick;
  assign tick = tick_cnt == 16'h0000;
  always_comb
  begin
    if (stall_decel && out_f != 16'h0000)
      next_ramp = DSCU_RS_DECEL;
    else if (out_f < target)
      next_ramp = accel_hold ? DSCU_RS_HOLD : DSCU_RS_ACCEL;
    else if (out_f > target)
      next_ramp = DSCU_RS_DECEL;
    else
      next_ramp = DSCU_RS_STEADY;
    if (next_ramp == DSCU_RS_DECEL)
      period = accel_set_select ? act.decel_time_set2 : act.decel_time_set1;
    else
      period = accel_set_select ? act.accel_time_set2 : act.accel_time_set1;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp <= DSCU_RS_STEADY;
      tick_cnt <= 16'h0000;
      out_f <= 16'h0000;
    end
    else if (ce)
    begin
      ramp <= next_ramp;
      tick_cnt <= (tick || period == 16'h0000) ? ((period == 16'h0000) ? 16'h0000 : period - 16'h0001) :
                  tick_cnt - 16'h0001;
      if (tick)
      begin
        case (next_ramp)
          DSCU_RS_ACCEL: out_f <= out_f + 16'h0001;
          DSCU_RS_DECEL: out_f <= out_f - 16'h0001;
          default: out_f <= out_f;
        endcase
      end
    end
  end

  assign status = '{run_cmd: run_cmd, reverse_cmd: reverse_cmd, accel_hold: accel_hold,
                    stall_decel: stall_decel, setting_error: setting_error,
                    comm_setting_error: comm_err, run_inhibit: comm_err,
                    freq_ref: freq_ref, output_freq: out_f};

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);
  sequence s_panel_start;
    act.run_source_select == `DSCU_RUN_SRC_PANEL && key_run && !key_stop && !comm_err;
  endsequence
  a_panel_run: assert property (s_panel_start |=> run_cmd)
    else $error("panel run key ignored");
  a_term_fwd: assert property (act.run_source_select == `DSCU_RUN_SRC_TERM && !seq2 && !three_wire
    && (|fwd_on) && !(|rev_on) && !comm_err |=> run_cmd && !reverse_cmd)
    else $error("terminal forward run wrong");
  a_seq2_dir: assert property (act.run_source_select == `DSCU_RUN_SRC_TERM && seq2
    |=> reverse_cmd == ~|$past(fr2_on))
    else $error("direction input wrong");
  a_conflict_rejected: assert property (cfg_load && conflict |=> setting_error && $stable(act))
    else $error("conflicting config accepted");
  a_comm_inhibit: assert property (comm_err |=> !run_cmd)
    else $error("run allowed after link conflict");
  a_ref_within_max: assert property ($stable(act) && (act.reference_source_select == `DSCU_REF_SRC_I4_20
    || act.reference_source_select == `DSCU_REF_SRC_I0_20) |=> freq_ref <= act.max_output_frequency)
    else $error("current reference above maximum");
  a_accel_off: assert property ((act.accel_stall_level == `DSCU_STALL_OFF)[*2] |-> !accel_hold)
    else $error("disabled accel stall acted");
  a_hold_no_rise: assert property (accel_hold && !stall_decel |=> out_f <= $past(out_f))
    else $error("frequency rose during hold");
  a_stall_after_wait: assert property ($rose(stall_decel) |-> $past(timer_done) && $past(over_run))
    else $error("run stall without qualification");
  a_step_on_tick: assert property (out_f != $past(out_f) |-> $past(tick))
    else $error("ramp stepped off tick");
endmodule
`default_nettype wire

/* File: tb/dscu_pulse_src.sv */
// pulse-train reference source standing in front of the command unit
// assumes clk is the unit's mclk; the train stands low while disabled
`timescale 1ns/100ps
`default_nettype none
module dscu_pulse_src (
  input wire logic clk,
  input wire logic en,
  input wire logic [7:0] half,
  output logic pulse
);
  logic [7:0] cnt;
  initial pulse = 1'b0;
  initial cnt = 8'h00;
  // the bench gate is shortened, so the rate is scaled up with it
  always @(posedge clk)
  begin
    if (!en)
    begin
      pulse <= 1'b0;
      cnt <= 8'h00;
    end
    else if (cnt == half - 8'h01)
    begin
      pulse <= ~pulse;
      cnt <= 8'h00;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of the drive speed command unit
// assumes the unit package and the pulse source model are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dscu_pkg::*;
  logic mclk, nrst, ce, cfg_load, cfg_from_comm, key_run, key_stop, panel_reverse, pulse_in, accel_set_select, pen;
  logic [2:0] terminal_in;
  logic [11:0] current_ref_adc;
  logic [15:0] digital_reference, f;
  logic [8:0] output_current;
  logic [31:0] rnd;
  dscu_cfg_t cfg, cfg_in;
  dscu_status_t status;
  int n_mismatch, checks_done, i;
  // short counts keep the run brief
  dscu_top #(.RUN_STALL_CYC(20), .GATE_CYC(50)) dscu_top_inst (.mclk(mclk), .nrst(nrst), .ce(ce),
    .cfg_in(cfg_in), .cfg_load(cfg_load), .cfg_from_comm(cfg_from_comm), .key_run(key_run), .key_stop(key_stop),
    .panel_reverse(panel_reverse), .terminal_in(terminal_in), .current_ref_adc(current_ref_adc),
    .pulse_in(pulse_in), .digital_reference(digital_reference), .output_current(output_current),
    .accel_set_select(accel_set_select), .status(status));
  dscu_pulse_src dscu_pulse_src_inst (.clk(mclk), .en(pen), .half(8'h05), .pulse(pulse_in));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // maximum frequency is 600 in every case of this bench
  function automatic logic [15:0] exp_ref(input logic [3:0] src, input logic [11:0] a);
    if (src == 4'h3)
      return 16'((32'(a - 12'h333) * 32'hBB8) >> 14);
    return 16'((32'(a) * 32'h258) >> 12);
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic load(input logic comm);
    @(posedge mclk);
    cfg_in <= cfg;
    cfg_load <= 1'b1;
    cfg_from_comm <= comm;
    @(posedge mclk);
    cfg_load <= 1'b0;
    tick(2);
  endtask
  task automatic drive(input logic [2:0] t, input logic [8:0] c, input logic r, input logic s);
    @(posedge mclk);
    terminal_in <= t;
    output_current <= c;
    key_run <= r;
    key_stop <= s;
    tick(3);
  endtask
  task automatic wait_out(input logic [15:0] v);
    for (i = 0; i < 3000 && status.output_freq !== v; i++)
      tick(1);
    if (i == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  initial
  begin
    {nrst, ce, cfg_load, cfg_from_comm, key_run, key_stop, panel_reverse, pen, accel_set_select} = 9'h080;
    terminal_in = 3'h0;
    current_ref_adc = 12'h000;
    output_current = 9'h000;
    digital_reference = 16'h01F4;
    rnd = 32'h0DD46703;
    n_mismatch = 0;
    checks_done = 0;
    cfg = '{2'h0, 4'h1, 12'h9C4, 6'h01, 6'h02, 6'h05, 8'h64, 8'h00, 16'h0258, 16'h0258, 8'hAA, 8'hA0, 1'b0,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
    cfg_in = cfg;
    tick(19);
    check(status, 0);
    @(posedge mclk);
    nrst <= 1'b1;
    tick(4);
    load(1'b0);
    drive(3'h0, 9'h000, 1'b1, 1'b0);
    drive(3'h0, 9'h000, 1'b0, 1'b0);
    check(status.run_cmd, 1);
    tick(20);
    // 180 % is above the default acceleration level of 170 %
    drive(3'h0, 9'h0B4, 1'b0, 1'b0);
    tick(2);
    f = status.output_freq;
    tick(5);
    check({status.accel_hold, status.output_freq}, {1'b1, f});
    drive(3'h0, 9'h0A6, 1'b0, 1'b0);
    check(status.accel_hold, 1);
    drive(3'h0, 9'h0A5, 1'b0, 1'b0);
    check(status.accel_hold, 0);
    wait_out(16'h01F4);
    tick(12);
    check(status.stall_decel, 0);
    // a dip to 100 % must restart the qualification count
    drive(3'h0, 9'h064, 1'b0, 1'b0);
    drive(3'h0, 9'h0A5, 1'b0, 1'b0);
    tick(16);
    check(status.stall_decel, 0);
    tick(6);
    check(status.stall_decel, 1);
    f = status.output_freq;
    tick(5);
    check(status.output_freq < f, 1);
    drive(3'h0, 9'h0A0, 1'b0, 1'b0);
    check(status.stall_decel, 0);
    wait_out(16'h01F4);
    cfg.accel_stall_level = 8'hC8;
    cfg.run_stall_level = 8'hC8;
    load(1'b0);
    drive(3'h0, 9'h0C7, 1'b0, 1'b0);
    tick(40);
    check(status.stall_decel, 0);
    drive(3'h0, 9'h0C7, 1'b0, 1'b1);
    tick(20);
    drive(3'h0, 9'h0C7, 1'b1, 1'b0);
    f = status.output_freq;
    tick(5);
    check({status.accel_hold, status.output_freq > f}, 2'b01);
    @(posedge mclk);
    panel_reverse <= 1'b1;
    tick(3);
    check(status.reverse_cmd, 1);
    // time set 2 paces the ramp; the voltage frequency drops below the output
    cfg.decel_time_set2 = 16'h000A;
    cfg.accel_stall_level = 8'hAA;
    cfg.max_voltage_frequency = 16'h00C8;
    load(1'b0);
    @(posedge mclk);
    accel_set_select <= 1'b1;
    drive(3'h0, 9'h0C7, 1'b0, 1'b1);
    f = status.output_freq;
    tick(40);
    check(f - status.output_freq, 16'h0004);
    // 100 % is under 170 % but over the level scaled by 200 over about 480
    drive(3'h0, 9'h064, 1'b1, 1'b0);
    check({status.run_cmd, status.accel_hold}, 2'b11);
    cfg.run_source_select = 2'h1;
    for (int k = 0; k < 12; k++)
    begin
      rnd = lfsr(rnd);
      cfg.reference_source_select = k[0] ? 4'h4 : 4'h3;
      @(posedge mclk);
      current_ref_adc <= (k < 2) ? (k[0] ? 12'hFFF : 12'h333) : 12'h333 + 12'(rnd % 32'hCCD);
      load(1'b0);
      check(status.freq_ref, exp_ref(cfg.reference_source_select, current_ref_adc));
    end
    cfg.reference_gain = 8'h32;
    load(1'b0);
    check(status.freq_ref, exp_ref(4'h4, current_ref_adc) >> 1);
    cfg.reference_gain = 8'h64;
    cfg.reference_source_select = 4'h5;
    cfg.pulse_full_scale_rate = 12'h064;
    @(posedge mclk);
    pen <= 1'b1;
    // five edges per gate over a full scale of 100 gives 30; 50 is clamped to 100
    for (int k = 0; k < 2; k++)
    begin
      load(1'b0);
      tick(140);
      check(status.freq_ref, 16'h001E);
      cfg.pulse_full_scale_rate = 12'h032;
    end
    load(1'b0);
    drive(3'h1, 9'h000, 1'b0, 1'b0);
    check({status.run_cmd, status.reverse_cmd}, 2'b10);
    drive(3'h2, 9'h000, 1'b0, 1'b0);
    check({status.run_cmd, status.reverse_cmd}, 2'b11);
    drive(3'h3, 9'h000, 1'b0, 1'b0);
    check(status.run_cmd, 0);
    cfg.input2_function = 6'h25;
    load(1'b0);
    check(status.run_cmd, 1);
    check(status.reverse_cmd, 0);
    drive(3'h1, 9'h000, 1'b0, 1'b0);
    check({status.run_cmd, status.reverse_cmd}, 2'b11);
    drive(3'h2, 9'h000, 1'b0, 1'b0);
    check(status.run_cmd, 0);
    cfg.input2_function = 6'h02;
    cfg.input3_function = 6'h00;
    load(1'b0);
    check(status.run_cmd, 0);
    drive(3'h3, 9'h000, 1'b0, 1'b0);
    check({status.run_cmd, status.reverse_cmd}, 2'b10);
    drive(3'h6, 9'h000, 1'b0, 1'b0);
    check({status.run_cmd, status.reverse_cmd}, 2'b11);
    drive(3'h4, 9'h000, 1'b0, 1'b0);
    check(status.run_cmd, 0);
    cfg.input3_function = 6'h25;
    load(1'b0);
    check({status.setting_error, status.comm_setting_error}, 2'b10);
    load(1'b1);
    drive(3'h3, 9'h000, 1'b0, 1'b0);
    check({status.comm_setting_error, status.run_inhibit, status.run_cmd}, 3'b110);
    cfg.input3_function = 6'h05;
    load(1'b0);
    check({status.setting_error, status.comm_setting_error}, 2'b00);
    finish_test();
  end
endmodule
`default_nettype wire
